//--- logic/amu_defs.svh
// Purpose: Register offsets, field positions, reset values and counts for the UART.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef AMU_DEFS_SVH
`define AMU_DEFS_SVH
`define AMU_OFS_MODE   8'h00
`define AMU_OFS_CTRL   8'h04
`define AMU_OFS_STAT   8'h08
`define AMU_OFS_TXD    8'h0C
`define AMU_OFS_RXD    8'h10
`define AMU_OFS_BAUD   8'h14
`define AMU_MODE_W     6
`define AMU_CTRL_W     6
`define AMU_STAT_W     8
`define AMU_MODE_RST   6'h00
`define AMU_CTRL_RST   6'h00
`define AMU_BAUD_RST   16'h0000
`define AMU_ST_TXE     0
`define AMU_ST_TXF     1
`define AMU_ST_RXF     2
`define AMU_ST_OVR     3
`define AMU_ST_FRM     4
`define AMU_ST_PAR     5
`define AMU_ST_MPR     6
`define AMU_ST_MPV     7
`define AMU_SAMPLE_CNT 4'h7
`define AMU_BIT_END    4'hF
`endif

//--- logic/amu_pkg.sv
// Purpose: Types shared by the UART design.
// Assumes: Constants live in amu_defs.svh.
// Notes:   Field order of the structs matches the register bit order.
`default_nettype none
package amu_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} amu_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} amu_rx_st_t;
  // Mode register, bit 5 down to bit 0.
  typedef struct packed {
    logic extClk;
    logic twoStop;
    logic mpMode;
    logic oddPar;
    logic parEn;
    logic chr7;
  } amu_mode_t;
  // Control register, bit 5 down to bit 0.
  typedef struct packed {
    logic mpWaitEn;
    logic rxIrqEn;
    logic txFinIrqEn;
    logic txEmptyIrqEn;
    logic rxOn;
    logic txOn;
  } amu_ctrl_t;
  // Interrupt request lines.
  typedef struct packed {
    logic txEmpty;
    logic txFin;
    logic rxFull;
    logic rxFault;
  } amu_irq_t;
endpackage
`default_nettype wire

//--- logic/amu_uart.sv
// Purpose: Asynchronous UART with double buffering, parity and multiprocessor format.
// Assumes: Inputs synchronous to core_clk; baud tick is 16 times the bit rate.
// Notes:   Operation
// Operation
// - Clearing tx empty flag means holding register has new data to send.
// - After loading shift register, set tx empty, start frame, request irq.
// - Frame starts with one low bit, then 7 or 8 data bits LSB first.
// - Then one parity bit, one multiprocessor bit, or none.
// - One or two high stop bits, then marking until next start.
// - During stop bit, reload if data waits, else set tx finished flag.
// - Receiver finds low start bit and shifts data in LSB first.
// - Parity enabled: count of ones must agree with odd/even selection.
// - Only first stop bit checked; zero sets framing flag, data still stored.
// - Data enters rx holding register only while rx full flag is zero.
// - Character ending while rx full is set raises overrun, holding kept.
// - Parity mismatch sets parity flag and still stores the data.
// - Any error flag blocks rx full and new reception until cleared.
// - Setting rx full raises rx full irq when rx irq enabled.
// - Any error flag with rx irq enabled raises rx fault irq.
// - Transfer controller reads/writes clear rx full/tx empty automatically.
// - Multiprocessor format replaces parity and ignores parity enable.
// - Multiprocessor bit sent equals the software mp bit value.
// - Waiting for ID, frames with mp bit zero are dropped silently.
// - Sync on start falling edge, sample on eighth of sixteen ticks.
// - Tx off sets tx empty, resets shifter; rx off keeps rx state.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "amu_defs.svh"
module amu_uart
  import amu_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Transfer controller marks its accesses with this level.
  input  wire logic        xferActive,
  // Serial line and external 16x clock.
  input  wire logic        rxd,
  input  wire logic        sck16,
  output logic             txd,
  // Interrupt requests.
  output amu_irq_t         irqReq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  amu_mode_t   mode_r,    mode_nxt;
  amu_ctrl_t   ctrl_r,    ctrl_nxt;
  logic [15:0] baudDiv_r, baudDiv_nxt;
  logic [15:0] baudCnt_r, baudCnt_nxt;
  logic        sckPrev_r, sckPrev_nxt;
  logic [7:0]  txHold_r,  txHold_nxt;
  logic [7:0]  txShift_r, txShift_nxt;
  logic        txPar_r,   txPar_nxt;
  logic        txEmpty_r, txEmpty_nxt;
  logic        txFin_r,   txFin_nxt;
  logic        mpBitV_r,  mpBitV_nxt;
  logic        txGo_r,    txGo_nxt;
  logic        txStop2_r, txStop2_nxt;
  logic [2:0]  txIdx_r,   txIdx_nxt;
  logic [3:0]  txCnt_r,   txCnt_nxt;
  amu_tx_st_t  txSt_r,    txSt_nxt;
  logic        txd_nxt;
  logic [7:0]  rxShift_r, rxShift_nxt;
  logic [7:0]  rxHold_r,  rxHold_nxt;
  logic        rxPar_r,   rxPar_nxt;
  logic        mpBitR_r,  mpBitR_nxt;
  logic        rxFull_r,  rxFull_nxt;
  logic        ovr_r,     ovr_nxt;
  logic        frm_r,     frm_nxt;
  logic        perr_r,    perr_nxt;
  logic        rxPrev_r,  rxPrev_nxt;
  logic [2:0]  rxIdx_r,   rxIdx_nxt;
  logic [3:0]  rxCnt_r,   rxCnt_nxt;
  amu_rx_st_t  rxSt_r,    rxSt_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  amu_irq_t    irq_nxt;

  // Builds a read word for an address; unmapped reads return zero.
  function automatic logic [31:0] readWord(input logic [7:0] a);
    unique case (a)
      `AMU_OFS_MODE: readWord = {26'h000_0000, mode_r};
      `AMU_OFS_CTRL: readWord = {26'h000_0000, ctrl_r};
      `AMU_OFS_STAT: readWord = {24'h00_0000, mpBitV_r, mpBitR_r, perr_r, frm_r,
                                 ovr_r, rxFull_r, txFin_r, txEmpty_r};
      `AMU_OFS_TXD:  readWord = {24'h00_0000, txHold_r};
      `AMU_OFS_RXD:  readWord = {24'h00_0000, rxHold_r};
      `AMU_OFS_BAUD: readWord = {16'h0000, baudDiv_r};
      default:       readWord = 32'h0000_0000;
    endcase
  endfunction

  // Tells whether an address is one of the six registers.
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `AMU_OFS_MODE) || (a == `AMU_OFS_CTRL) || (a == `AMU_OFS_STAT)
            || (a == `AMU_OFS_TXD) || (a == `AMU_OFS_RXD) || (a == `AMU_OFS_BAUD);
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       tick;
  logic       fall;
  logic       anyErr;
  logic       lastStop;
  logic [7:0] rxDat;
  logic [2:0] lastIdx;
  logic       useBit;

  // Computes the bus answer, baud tick, transmitter and receiver.
  always_comb begin
    mode_nxt    = mode_r;
    ctrl_nxt    = ctrl_r;
    baudDiv_nxt = baudDiv_r;
    baudCnt_nxt = baudCnt_r;
    txHold_nxt  = txHold_r;
    txShift_nxt = txShift_r;
    txPar_nxt   = txPar_r;
    txEmpty_nxt = txEmpty_r;
    txFin_nxt   = txFin_r;
    mpBitV_nxt  = mpBitV_r;
    txGo_nxt    = txGo_r;
    txStop2_nxt = txStop2_r;
    txIdx_nxt   = txIdx_r;
    txCnt_nxt   = txCnt_r;
    txSt_nxt    = txSt_r;
    txd_nxt     = txd;
    rxShift_nxt = rxShift_r;
    rxHold_nxt  = rxHold_r;
    rxPar_nxt   = rxPar_r;
    mpBitR_nxt  = mpBitR_r;
    rxFull_nxt  = rxFull_r;
    ovr_nxt     = ovr_r;
    frm_nxt     = frm_r;
    perr_nxt    = perr_r;
    rxIdx_nxt   = rxIdx_r;
    rxCnt_nxt   = rxCnt_r;
    rxSt_nxt    = rxSt_r;
    rxPrev_nxt  = rxd;
    sckPrev_nxt = sck16;
    lastStop    = 1'b0;
    rxDat       = mode_r.chr7 ? {1'b0, rxShift_r[7:1]} : rxShift_r;
    lastIdx     = mode_r.chr7 ? 3'h6 : 3'h7;
    useBit      = mode_r.mpMode | mode_r.parEn;
    anyErr      = ovr_r | frm_r | perr_r;
    fall        = rxPrev_r & ~rxd;
    // Bus: zero-wait answer, read data prepared in the setup cycle.
    acc         = psel & penable & pready;
    wr          = acc & pwrite;
    pready_nxt  = psel & ~penable;
    prdata_nxt  = (psel & ~penable & ~pwrite) ? readWord(paddr) : prdata;
    pslverr_nxt = psel & ~penable & ~isMapped(paddr);

    // Register writes; status flags are cleared by writing zero.
    if (wr) begin
      unique case (paddr)
        `AMU_OFS_MODE: mode_nxt = amu_mode_t'(pwdata[`AMU_MODE_W-1:0]);
        `AMU_OFS_CTRL: ctrl_nxt = amu_ctrl_t'(pwdata[`AMU_CTRL_W-1:0]);
        `AMU_OFS_BAUD: baudDiv_nxt = pwdata[15:0];
        `AMU_OFS_TXD: begin
          txHold_nxt = pwdata[7:0];
          if (xferActive) txEmpty_nxt = 1'b0;
        end
        `AMU_OFS_STAT: begin
          if (!pwdata[`AMU_ST_TXE]) txEmpty_nxt = 1'b0;
          if (!pwdata[`AMU_ST_TXF]) txFin_nxt = 1'b0;
          if (!pwdata[`AMU_ST_RXF]) rxFull_nxt = 1'b0;
          if (!pwdata[`AMU_ST_OVR]) ovr_nxt = 1'b0;
          if (!pwdata[`AMU_ST_FRM]) frm_nxt = 1'b0;
          if (!pwdata[`AMU_ST_PAR]) perr_nxt = 1'b0;
          mpBitV_nxt = pwdata[`AMU_ST_MPV];
        end
        default: ;
      endcase
    end
    if (acc && !pwrite && paddr == `AMU_OFS_RXD && xferActive) begin
      rxFull_nxt = 1'b0;
    end

    // Baud tick: internal divider or rising edge of the external 16x clock.
    if (mode_r.extClk) begin
      tick        = sck16 & ~sckPrev_r;
      baudCnt_nxt = 16'h0000;
    end else begin
      tick        = (baudCnt_r == baudDiv_r);
      baudCnt_nxt = tick ? 16'h0000 : baudCnt_r + 16'h0001;
    end

    // Transmitter.
    if (!ctrl_r.txOn) begin
      txSt_nxt    = TX_IDLE;
      txEmpty_nxt = 1'b1;
      txShift_nxt = 8'h00;
      txGo_nxt    = 1'b0;
      txd_nxt     = 1'b1;
    end else begin
      unique case (txSt_r)
        TX_IDLE: begin
          txd_nxt = 1'b1;
          if (!txEmpty_r) begin
            txShift_nxt = txHold_r;
            txPar_nxt   = mode_r.mpMode ? mpBitV_r
                        : (^(txHold_r & {~mode_r.chr7, 7'h7F})) ^ mode_r.oddPar;
            txEmpty_nxt = 1'b1;
            txFin_nxt   = 1'b0;
            txSt_nxt    = TX_START;
            txCnt_nxt   = 4'h0;
            txd_nxt     = 1'b0;
          end
        end
        default: begin
          if (tick) begin
            txCnt_nxt = txCnt_r + 4'h1;
            if (txCnt_r == `AMU_BIT_END) begin
              unique case (txSt_r)
                TX_START: begin
                  txSt_nxt  = TX_DATA;
                  txIdx_nxt = 3'h0;
                  txd_nxt   = txShift_r[0];
                end
                TX_DATA: begin
                  if (txIdx_r == lastIdx) begin
                    if (useBit) begin
                      txSt_nxt = TX_PAR;
                      txd_nxt  = txPar_r;
                    end else begin
                      txSt_nxt    = TX_STOP;
                      txStop2_nxt = mode_r.twoStop;
                      txd_nxt     = 1'b1;
                      lastStop    = ~mode_r.twoStop;
                    end
                  end else begin
                    txShift_nxt = {1'b0, txShift_r[7:1]};
                    txIdx_nxt   = txIdx_r + 3'h1;
                    txd_nxt     = txShift_r[1];
                  end
                end
                TX_PAR: begin
                  txSt_nxt    = TX_STOP;
                  txStop2_nxt = mode_r.twoStop;
                  txd_nxt     = 1'b1;
                  lastStop    = ~mode_r.twoStop;
                end
                default: begin
                  if (txStop2_r) begin
                    txStop2_nxt = 1'b0;
                    lastStop    = 1'b1;
                  end else if (txGo_r) begin
                    txGo_nxt    = 1'b0;
                    txSt_nxt    = TX_START;
                    txd_nxt     = 1'b0;
                  end else begin
                    txSt_nxt    = TX_IDLE;
                  end
                end
              endcase
            end
          end
        end
      endcase
      // On entry to the final stop bit, chain the next frame or finish.
      if (lastStop) begin
        if (!txEmpty_r) begin
          txShift_nxt = txHold_r;
          txPar_nxt   = mode_r.mpMode ? mpBitV_r
                      : (^(txHold_r & {~mode_r.chr7, 7'h7F})) ^ mode_r.oddPar;
          txEmpty_nxt = 1'b1;
          txGo_nxt    = 1'b1;
        end else begin
          txFin_nxt   = 1'b1;
        end
      end
    end

    // Receiver: samples on the eighth tick of each sixteen-tick bit.
    if (!ctrl_r.rxOn) begin
      rxSt_nxt = RX_IDLE;
    end else if (rxSt_r == RX_IDLE) begin
      if (fall && !anyErr) begin
        rxSt_nxt  = RX_START;
        rxCnt_nxt = 4'h0;
      end
    end else if (tick) begin
      rxCnt_nxt = rxCnt_r + 4'h1;
      if (rxCnt_r == `AMU_SAMPLE_CNT) begin
        unique case (rxSt_r)
          RX_START: begin
            rxSt_nxt  = rxd ? RX_IDLE : RX_DATA;
            rxIdx_nxt = 3'h0;
          end
          RX_DATA: begin
            rxShift_nxt = {rxd, rxShift_r[7:1]};
            rxIdx_nxt   = rxIdx_r + 3'h1;
            if (rxIdx_r == lastIdx) rxSt_nxt = useBit ? RX_PAR : RX_STOP;
          end
          RX_PAR: begin
            rxPar_nxt = rxd;
            rxSt_nxt  = RX_STOP;
          end
          default: begin
            rxSt_nxt = RX_IDLE;
            if (mode_r.mpMode && ctrl_r.mpWaitEn && !rxPar_r) begin
              rxSt_nxt = RX_IDLE;
            end else begin
              if (mode_r.mpMode && ctrl_r.mpWaitEn) ctrl_nxt.mpWaitEn = 1'b0;
              if (rxFull_r) begin
                ovr_nxt = 1'b1;
              end else begin
                rxHold_nxt = rxDat;
                mpBitR_nxt = rxPar_r;
                if (!rxd) frm_nxt = 1'b1;
                if (mode_r.parEn && !mode_r.mpMode && ((^rxDat ^ rxPar_r) != mode_r.oddPar)) begin
                  perr_nxt = 1'b1;
                end else if (rxd) begin
                  rxFull_nxt = 1'b1;
                end
              end
            end
          end
        endcase
      end
    end

    // Interrupt requests follow the next flag values.
    irq_nxt.txEmpty = ctrl_nxt.txEmptyIrqEn & txEmpty_nxt & ctrl_nxt.txOn;
    irq_nxt.txFin   = ctrl_nxt.txFinIrqEn & txFin_nxt;
    irq_nxt.rxFull  = ctrl_nxt.rxIrqEn & rxFull_nxt;
    irq_nxt.rxFault = ctrl_nxt.rxIrqEn & (ovr_nxt | frm_nxt | perr_nxt);
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Stores all next values; reset gives idle line, empty buffers.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r    <= amu_mode_t'(`AMU_MODE_RST);
      ctrl_r    <= amu_ctrl_t'(`AMU_CTRL_RST);
      baudDiv_r <= `AMU_BAUD_RST;
      baudCnt_r <= 16'h0000;
      sckPrev_r <= 1'b0;
      txHold_r  <= 8'h00;
      txShift_r <= 8'h00;
      txPar_r   <= 1'b0;
      txEmpty_r <= 1'b1;
      txFin_r   <= 1'b1;
      mpBitV_r  <= 1'b0;
      txGo_r    <= 1'b0;
      txStop2_r <= 1'b0;
      txIdx_r   <= 3'h0;
      txCnt_r   <= 4'h0;
      txSt_r    <= TX_IDLE;
      txd       <= 1'b1;
      rxShift_r <= 8'h00;
      rxHold_r  <= 8'h00;
      rxPar_r   <= 1'b0;
      mpBitR_r  <= 1'b0;
      rxFull_r  <= 1'b0;
      ovr_r     <= 1'b0;
      frm_r     <= 1'b0;
      perr_r    <= 1'b0;
      rxPrev_r  <= 1'b1;
      rxIdx_r   <= 3'h0;
      rxCnt_r   <= 4'h0;
      rxSt_r    <= RX_IDLE;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      irqReq    <= '0;
    end else begin
      mode_r    <= mode_nxt;
      ctrl_r    <= ctrl_nxt;
      baudDiv_r <= baudDiv_nxt;
      baudCnt_r <= baudCnt_nxt;
      sckPrev_r <= sckPrev_nxt;
      txHold_r  <= txHold_nxt;
      txShift_r <= txShift_nxt;
      txPar_r   <= txPar_nxt;
      txEmpty_r <= txEmpty_nxt;
      txFin_r   <= txFin_nxt;
      mpBitV_r  <= mpBitV_nxt;
      txGo_r    <= txGo_nxt;
      txStop2_r <= txStop2_nxt;
      txIdx_r   <= txIdx_nxt;
      txCnt_r   <= txCnt_nxt;
      txSt_r    <= txSt_nxt;
      txd       <= txd_nxt;
      rxShift_r <= rxShift_nxt;
      rxHold_r  <= rxHold_nxt;
      rxPar_r   <= rxPar_nxt;
      mpBitR_r  <= mpBitR_nxt;
      rxFull_r  <= rxFull_nxt;
      ovr_r     <= ovr_nxt;
      frm_r     <= frm_nxt;
      perr_r    <= perr_nxt;
      rxPrev_r  <= rxPrev_nxt;
      rxIdx_r   <= rxIdx_nxt;
      rxCnt_r   <= rxCnt_nxt;
      rxSt_r    <= rxSt_nxt;
      prdata    <= prdata_nxt;
      pready    <= pready_nxt;
      pslverr   <= pslverr_nxt;
      irqReq    <= irq_nxt;
    end
  end

endmodule
`default_nettype wire

//--- sim/amu_uart_assertions.sv
// Purpose: Port-level checks of the UART bus timing and serial line.
// Assumes: Baud divisor 0, so one serial bit lasts 16 core clocks.
// Notes:   Bound to every amu_uart instance.
`timescale 1ns/100ps
`default_nettype none
module amu_uart_assertions
  import amu_pkg::*;
(
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Register bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial lines and requests.
  input wire logic        rxd,
  input wire logic        txd,
  input wire amu_irq_t    irqReq
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Every check runs on the core clock and rests during reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  unmapped_err_a: assert property (pready && (paddr > 8'h14 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  read_upper_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data upper bits set");
  low_width_a: assert property ($fell(txd) |-> !txd [*8] ##1 !txd [*8])
    else $error("low bit shorter than 16 clocks");
  high_width_a: assert property ($rose(txd) |-> txd [*8] ##1 txd [*8])
    else $error("high bit shorter than 16 clocks");
  fin_marking_a: assert property ($rose(irqReq.txFin) |-> txd [*8])
    else $error("finish request without marking");
  full_stop_a: assert property ($rose(irqReq.rxFull) |-> rxd)
    else $error("full request without high stop");
  // Main scenarios seen on the ports.
  cover property ($rose(irqReq.rxFull));
  cover property ($rose(irqReq.rxFault));
  cover property ($rose(irqReq.txFin));
endmodule
bind amu_uart amu_uart_assertions u_amu_uart_assertions (.core_clk(core_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd(rxd), .txd(txd), .irqReq(irqReq));
`default_nettype wire

//--- sim/amu_remote_node.sv
// Purpose: Remote serial node that frames bytes onto rxd and decodes txd.
// Assumes: One bit lasts BIT_CYC core clocks.
// Notes:   The bench sets the frame layout through nData and hasExtra.
`timescale 1ns/100ps
`default_nettype none
module amu_remote_node #(
  parameter int BIT_CYC = 16
) (
  // Clock.
  input  wire logic core_clk,
  // Line from the device.
  input  wire logic txd,
  // Line to the device, marking when idle.
  output var logic  rxd
);
  int         nData = 8;
  logic       hasExtra = 1'b1;
  logic [9:0] got[$];
  logic [9:0] w;
  // ---------------------------------------------------------------
  // Sender and receiver
  // ---------------------------------------------------------------
  initial rxd = 1'b1;
  // Holds one bit for a full bit time, changing just after an edge.
  task automatic put_bit(input logic v);
    rxd <= v;
    repeat (BIT_CYC) @(posedge core_clk);
  endtask
  // Start, data LSB first, optional parity or mp bit, one stop, then marking.
  task automatic send(input logic [7:0] d, input logic ex, input logic stp);
    put_bit(1'b0);
    for (int i = 0; i < nData; i++) put_bit(d[i]);
    if (hasExtra) put_bit(ex);
    put_bit(stp);
    rxd <= 1'b1;
  endtask
  // Decodes each frame on txd at the middle of every bit.
  initial begin
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      w = '0;
      for (int i = 0; i < nData + 32'(hasExtra); i++) begin
        repeat (BIT_CYC) @(posedge core_clk);
        w[(i < nData) ? i : 8] = txd;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      w[9] = txd;
      got.push_back(w);
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_amu_uart.sv
// Purpose: Self-checking bench for the UART over APB and the serial line.
// Assumes: Baud divisor 0, so one serial bit lasts 16 core clocks.
// Notes:   The remote node model drives rxd and decodes txd.
`timescale 1ns/100ps
`default_nettype none
`include "amu_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH at %0t: got %h exp %h", $time, g, e); end end
module tb_amu_uart
  import amu_pkg::*;
;
  logic        core_clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        xferActive;
  logic        rxd;
  logic        sck16;
  logic        txd;
  amu_irq_t    irqReq;
  logic [31:0] rdata;
  logic        lastErr;
  int          bad_count;
  int          cmp_count;
  logic [5:0]  fmt [4] = '{6'h06, 6'h01, 6'h0B, 6'h1A};
  logic [7:0]  dat [4] = '{8'hA4, 8'hD5, 8'h33, 8'h0F};
  // ---------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------
  // Free-running 40 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  amu_uart u_amu_uart (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xferActive(xferActive), .rxd(rxd), .sck16(sck16), .txd(txd), .irqReq(irqReq));
  amu_remote_node u_node (.core_clk(core_clk), .txd(txd), .rxd(rxd));
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One APB transfer; the wait for pready is bounded.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
    rdata = prdata;
    lastErr = pslverr;
    psel       <= 1'b0;
    penable    <= 1'b0;
    xferActive <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  // Reads a register and compares the masked value.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK(rdata & m, e)
  endtask
  // Stops both directions, sets the format, restarts and waits one bit time.
  task automatic cfg(input logic [5:0] m, input logic [5:0] c);
    wr(`AMU_OFS_CTRL, 32'h0);
    wr(`AMU_OFS_MODE, {26'h0, m});
    wr(`AMU_OFS_CTRL, {26'h0, c});
    repeat (16) @(posedge core_clk);
    u_node.nData = m[0] ? 7 : 8;
    u_node.hasExtra = m[1] | m[3];
  endtask
  // Waits, under a bound, until the node has decoded n frames.
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (u_node.got.size() < n && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 4000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  // Compares one decoded frame with the format the mode asks for.
  task automatic frame_chk(input logic [7:0] d, input logic [5:0] m, input logic mpv);
    logic [7:0] v;
    logic [9:0] f;
    v = m[0] ? {1'b0, d[6:0]} : d;
    f = u_node.got.pop_front();
    `CHK(f, {1'b1, m[3] ? mpv : (m[1] & (^v ^ m[2])), v})
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    bad_count = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    xferActive = 1'b0;
    sck16 = 1'b0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    // Reset values and two unmapped places.
    rd(`AMU_OFS_STAT, 32'h3F, 32'h03);
    rd(`AMU_OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
    apb(8'h20, 1'b0, 32'h0);
    `CHK({lastErr, rdata}, {1'b1, 32'h0})
    wr(8'h24, 32'h0);
    `CHK(lastErr, 1'b1)
    // Two frames back to back, the second written by the controller.
    cfg(6'h02, 6'h1F);
    wr(`AMU_OFS_TXD, 32'hA4);
    wr(`AMU_OFS_STAT, 32'h7E);
    rd(`AMU_OFS_STAT, 32'h03, 32'h01);
    `CHK(irqReq.txEmpty, 1'b1)
    xferActive <= 1'b1;
    wr(`AMU_OFS_TXD, 32'h3C);
    rd(`AMU_OFS_STAT, 32'h03, 32'h00);
    wait_frames(2);
    frame_chk(8'hA4, 6'h02, 1'b0);
    frame_chk(8'h3C, 6'h02, 1'b0);
    rd(`AMU_OFS_STAT, 32'h03, 32'h03);
    `CHK(irqReq.txFin, 1'b1)
    // Four frame layouts, with both mp bit values.
    for (int i = 0; i < 4; i++) begin
      cfg(fmt[i], 6'h1F);
      wr(`AMU_OFS_TXD, {24'h0, dat[i]});
      wr(`AMU_OFS_STAT, {24'h0, i[0], 7'h7E});
      wait_frames(1);
      frame_chk(dat[i], fmt[i], i[0]);
    end
    // Good frame, then receiver off keeps state and ignores the line.
    cfg(6'h02, 6'h1F);
    u_node.send(8'h5A, ^8'h5A, 1'b1);
    rd(`AMU_OFS_STAT, 32'h3C, 32'h04);
    `CHK(irqReq.rxFull, 1'b1)
    wr(`AMU_OFS_CTRL, 32'h1D);
    u_node.send(8'h66, ^8'h66, 1'b1);
    rd(`AMU_OFS_STAT, 32'h3C, 32'h04);
    wr(`AMU_OFS_CTRL, 32'h1F);
    u_node.send(8'h66, ^8'h66, 1'b1);
    rd(`AMU_OFS_STAT, 32'h3C, 32'h0C);
    `CHK(irqReq.rxFault, 1'b1)
    rd(`AMU_OFS_RXD, 32'hFF, 32'h5A);
    wr(`AMU_OFS_STAT, 32'h03);
    // Parity fault stores data and blocks the next frame.
    u_node.send(8'h71, ~^8'h71, 1'b1);
    rd(`AMU_OFS_STAT, 32'h3C, 32'h20);
    rd(`AMU_OFS_RXD, 32'hFF, 32'h71);
    u_node.send(8'h11, ^8'h11, 1'b1);
    rd(`AMU_OFS_STAT, 32'h3C, 32'h20);
    rd(`AMU_OFS_RXD, 32'hFF, 32'h71);
    wr(`AMU_OFS_STAT, 32'h03);
    u_node.send(8'h2E, ^8'h2E, 1'b0);
    rd(`AMU_OFS_STAT, 32'h3C, 32'h10);
    rd(`AMU_OFS_RXD, 32'hFF, 32'h2E);
    wr(`AMU_OFS_STAT, 32'h03);
    // Waiting for an ID: payload dropped, ID delivered, wait released.
    cfg(6'h0A, 6'h3F);
    u_node.send(8'h22, 1'b0, 1'b1);
    rd(`AMU_OFS_STAT, 32'h3C, 32'h00);
    u_node.send(8'h47, 1'b1, 1'b1);
    rd(`AMU_OFS_STAT, 32'h7C, 32'h44);
    rd(`AMU_OFS_CTRL, 32'h3F, 32'h1F);
    xferActive <= 1'b1;
    rd(`AMU_OFS_RXD, 32'hFF, 32'h47);
    rd(`AMU_OFS_STAT, 32'h3C, 32'h00);
    u_node.send(8'h22, 1'b0, 1'b1);
    rd(`AMU_OFS_RXD, 32'hFF, 32'h22);
    wr(`AMU_OFS_CTRL, 32'h3F);
    wr(`AMU_OFS_STAT, 32'h03);
    u_node.send(8'h35, 1'b0, 1'b1);
    rd(`AMU_OFS_STAT, 32'h3C, 32'h00);
    rd(`AMU_OFS_RXD, 32'hFF, 32'h22);
    tally_and_finish();
  end
endmodule
`default_nettype wire
